// [rtl/tws_top.sv]
// Two-wire clocked serial channel with an APB register port.
//
// Contract
// - Two select bits pick external, timer, prescaler.
// - Mode bits 11 give two-wire; bit picks line.
// - Wake-up zero: request after every transfer.
// - Compare flag: slave address equals shift register, while enabled.
// - Enable bit zero stops the channel.
// - Release sets latch, command clears; both self-clear.
// - Shift on falling clock edge, MSB first.
// - Sample data line on rising clock edge.
// - Stop after eight bits; set request only when wake-up is zero.
// - Start needs enable and idle clock high.
// - Late enable never starts an earlier write.
// - Bus level shifts back for error check.
// - Idle clock sits high; port latch pulses.
// - Clock level status reads zero when disabled.
`timescale 1ns/100ps
`include "tws_consts.svh"

module tws_top (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [19:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timerTwoOut,
    input  wire logic        serialClockLineIn,
    output logic             serialClockLineOut,
    output logic             serialClockLineOe,
    input  wire logic        dataLineAIn,
    output logic             dataLineAOut,
    output logic             dataLineAOe,
    input  wire logic        dataLineBIn,
    output logic             dataLineBOut,
    output logic             dataLineBOe,
    output logic             channelIrq
);
    import tws_pkg::*;

    tws_regs_type s_r;
    tws_regs_type s_nxt;
    logic [2:0]   pinSync;
    logic         halfTick;
    logic         sckSync;
    logic         dataIn;
    logic         extClock;
    logic         enable;
    logic         twoWire;
    logic         fire;
    logic         wrEn;
    logic [17:0]  regIdx;
    logic         sckRise;
    logic         sckFall;
    logic         startOk;

    // ----------------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------------
    function automatic logic isMapped(input logic [17:0] idx);
        case (idx)
            `TWS_IDX_SHIFT, `TWS_IDX_SLAVE, `TWS_IDX_PRESC, `TWS_IDX_MODE,
            `TWS_IDX_BUSCTL, `TWS_IDX_INTTIM, `TWS_IDX_PORT,
            `TWS_IDX_STATUS: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    function automatic logic [7:0] readReg(input logic [17:0] idx,
                                           input tws_regs_type r,
                                           input logic cmpFlag,
                                           input logic clkLevel);
        logic [7:0] m;
        logic [7:0] t;
        m = r.mode;
        m[`TWS_MODE_COMPARE] = cmpFlag;
        t = r.intTim;
        t[`TWS_INTTIM_CLKLVL] = clkLevel;
        case (idx)
            `TWS_IDX_SHIFT:  readReg = r.shiftReg;
            `TWS_IDX_SLAVE:  readReg = r.slaveAddr;
            `TWS_IDX_PRESC:  readReg = {4'h0, r.presc};
            `TWS_IDX_MODE:   readReg = m;
            `TWS_IDX_BUSCTL: readReg = {r.busCtlHi, 2'b00};
            `TWS_IDX_INTTIM: readReg = t;
            `TWS_IDX_PORT:   readReg = {6'h00, r.portDir, r.portLatch};
            `TWS_IDX_STATUS: readReg = {7'h00, r.irqFlag};
            default:         readReg = 8'h00;
        endcase
    endfunction

    tws_sync u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pinIn   ({serialClockLineIn, dataLineAIn, dataLineBIn}),
        .pinSync (pinSync)
    );

    tws_clkgen u_clkgen (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .run         ((s_r.st == TWS_SHIFT) && !extClock),
        .useTimer    (!s_r.mode[`TWS_MODE_CLKSEL_LO]),
        .prescSel    (s_r.presc),
        .timerTwoOut (timerTwoOut),
        .halfTick    (halfTick)
    );

    // ----------------------------------------------------------------------
    // Channel decode and serial clock edges
    // ----------------------------------------------------------------------
    always_comb begin
        sckSync  = pinSync[2];
        enable   = s_r.mode[`TWS_MODE_ENABLE];
        extClock = !s_r.mode[`TWS_MODE_CLKSEL_HI];
        twoWire  = enable &&
                   (s_r.mode[`TWS_MODE_OP_HI:`TWS_MODE_OP_LO] == `TWS_OP_TWO_WIRE);
        // Bit clear selects line B; set selects line A.
        dataIn   = s_r.mode[`TWS_MODE_LINE_SEL] ? pinSync[1] : pinSync[0];
        regIdx   = paddr[19:2];
        fire     = psel && penable && s_r.pready;
        wrEn     = fire && pwrite;
        if (extClock) begin
            sckRise = sckSync && !s_r.sckPrev;
            sckFall = !sckSync && s_r.sckPrev;
        end else begin
            sckRise = halfTick && !s_r.sckInt;
            sckFall = halfTick && s_r.sckInt;
        end
        // The internal clock is stopped whenever no byte is in flight.
        startOk = enable && (s_r.st == TWS_IDLE) && (!extClock || sckSync);
    end

    // ----------------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.sckPrev = sckSync;

        // One wait state: the read data are captured when pready rises.
        s_nxt.pready  = psel && penable && !s_r.pready;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata  = 32'h0000_0000;
        if (s_nxt.pready) begin
            s_nxt.prdata = {24'h00_0000,
                            readReg(regIdx, s_r,
                                    enable && (s_r.slaveAddr == s_r.shiftReg),
                                    enable && sckSync)};
            s_nxt.pslverr = !isMapped(regIdx);
        end

        if (wrEn) begin
            case (regIdx)
                `TWS_IDX_SHIFT: begin
                    // A write during a transfer would corrupt the byte in flight.
                    if (s_r.st == TWS_IDLE) begin
                        s_nxt.shiftReg = pwdata[7:0];
                    end
                    if (startOk) begin
                        s_nxt.st = TWS_SHIFT;
                        s_nxt.bitCnt = 3'h0;
                    end
                end
                `TWS_IDX_SLAVE:  s_nxt.slaveAddr = pwdata[7:0];
                `TWS_IDX_PRESC:  s_nxt.presc = pwdata[3:0];
                `TWS_IDX_MODE: begin
                    s_nxt.mode = pwdata[7:0];
                    s_nxt.mode[`TWS_MODE_COMPARE] = 1'b0;
                end
                `TWS_IDX_BUSCTL: begin
                    s_nxt.busCtlHi = pwdata[7:2];
                    // Triggers are not stored, so they read back as zero.
                    if (pwdata[`TWS_BUSCTL_RELEASE]) begin
                        s_nxt.outLatch = 1'b1;
                    end
                    if (pwdata[`TWS_BUSCTL_COMMAND]) begin
                        s_nxt.outLatch = 1'b0;
                    end
                end
                `TWS_IDX_INTTIM: begin
                    s_nxt.intTim = pwdata[7:0];
                    s_nxt.intTim[`TWS_INTTIM_CLKLVL] = 1'b0;
                end
                `TWS_IDX_PORT: begin
                    s_nxt.portLatch = pwdata[`TWS_PORT_LATCH];
                    s_nxt.portDir = pwdata[`TWS_PORT_DIR];
                end
                `TWS_IDX_STATUS: begin
                    if (pwdata[`TWS_STATUS_IRQ]) begin
                        s_nxt.irqFlag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Shift engine; it runs after the register writes so a new
        // completion wins over a clear in the same cycle.
        case (s_r.st)
            TWS_SHIFT: begin
                if (!extClock && halfTick) begin
                    s_nxt.sckInt = !s_r.sckInt;
                end
                if (sckFall) begin
                    s_nxt.outLatch = s_r.shiftReg[7];
                    s_nxt.shiftReg = {s_r.shiftReg[6:0], s_r.shiftReg[0]};
                end
                if (sckRise) begin
                    // The selected pin is read, not the latch, so a lost bit
                    // shows up as a changed byte.
                    s_nxt.shiftReg[0] = dataIn;
                    s_nxt.bitCnt = s_r.bitCnt + 3'h1;
                    if (s_r.bitCnt == `TWS_LAST_BIT) begin
                        s_nxt.st = TWS_IDLE;
                        s_nxt.sckInt = 1'b1;
                        if (!s_r.mode[`TWS_MODE_WAKE]) begin
                            s_nxt.irqFlag = 1'b1;
                        end
                    end
                end
            end
            default: begin
                s_nxt.sckInt = 1'b1;
            end
        endcase

        if (!s_nxt.mode[`TWS_MODE_ENABLE]) begin
            s_nxt.st = TWS_IDLE;
            s_nxt.sckInt = 1'b1;
            s_nxt.bitCnt = 3'h0;
        end

        // ------------------------------------------------------------------
        // Pin drivers: open drain, so the device only ever pulls low.
        // ------------------------------------------------------------------
        s_nxt.dataAOe = s_nxt.mode[`TWS_MODE_ENABLE] &&
                        (s_nxt.mode[`TWS_MODE_OP_HI:`TWS_MODE_OP_LO] == `TWS_OP_TWO_WIRE) &&
                        s_nxt.mode[`TWS_MODE_LINE_SEL] && !s_nxt.outLatch;
        s_nxt.dataBOe = s_nxt.mode[`TWS_MODE_ENABLE] &&
                        (s_nxt.mode[`TWS_MODE_OP_HI:`TWS_MODE_OP_LO] == `TWS_OP_TWO_WIRE) &&
                        !s_nxt.mode[`TWS_MODE_LINE_SEL] && !s_nxt.outLatch;
        // Clock output needs direction 0; the port latch gates the clock so
        // software can add pulses while the channel is idle.
        s_nxt.sckOe = s_nxt.mode[`TWS_MODE_ENABLE] &&
                      (s_nxt.mode[`TWS_MODE_OP_HI:`TWS_MODE_OP_LO] == `TWS_OP_TWO_WIRE) &&
                      s_nxt.mode[`TWS_MODE_CLKSEL_HI] && !s_nxt.portDir &&
                      (!s_nxt.sckInt || !s_nxt.portLatch);
    end

    // ----------------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '{st: TWS_IDLE, shiftReg: `TWS_RST_SHIFT, slaveAddr: `TWS_RST_SLAVE,
                     mode: `TWS_RST_MODE, busCtlHi: `TWS_RST_BUSCTL,
                     intTim: `TWS_RST_INTTIM, presc: `TWS_RST_PRESC,
                     portLatch: 1'b0, portDir: 1'b1, irqFlag: 1'b0,
                     outLatch: 1'b1, sckInt: 1'b1, sckPrev: 1'b1, bitCnt: 3'h0,
                     pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
                     sckOe: 1'b0, dataAOe: 1'b0, dataBOe: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata             = s_r.prdata;
    assign pready             = s_r.pready;
    assign pslverr            = s_r.pslverr;
    assign serialClockLineOut = 1'b0;
    assign serialClockLineOe  = s_r.sckOe;
    assign dataLineAOut       = 1'b0;
    assign dataLineAOe        = s_r.dataAOe;
    assign dataLineBOut       = 1'b0;
    assign dataLineBOe        = s_r.dataBOe;
    assign channelIrq         = s_r.irqFlag;
endmodule

// [rtl/tws_consts.svh]
// Offsets, field positions, reset values and timing counts of the two-wire serial channel.
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------------
`define TWS_IDX_SHIFT    18'h0ff1a
`define TWS_IDX_SLAVE    18'h0ff1d
`define TWS_IDX_PRESC    18'h0ff43
`define TWS_IDX_MODE     18'h0ff60
`define TWS_IDX_BUSCTL   18'h0ff61
`define TWS_IDX_INTTIM   18'h0ff63
`define TWS_IDX_PORT     18'h0ff70
`define TWS_IDX_STATUS   18'h0ff71

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TWS_MODE_CLKSEL_HI   1
`define TWS_MODE_CLKSEL_LO   0
`define TWS_MODE_LINE_SEL    2
`define TWS_MODE_OP_HI       4
`define TWS_MODE_OP_LO       3
`define TWS_MODE_WAKE        5
`define TWS_MODE_COMPARE     6
`define TWS_MODE_ENABLE      7
`define TWS_BUSCTL_RELEASE   0
`define TWS_BUSCTL_COMMAND   1
`define TWS_INTTIM_CLKLVL    6
`define TWS_PORT_LATCH       0
`define TWS_PORT_DIR         1
`define TWS_STATUS_IRQ       0

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define TWS_RST_MODE     8'h00
`define TWS_RST_BUSCTL   6'h00
`define TWS_RST_INTTIM   8'h00
`define TWS_RST_PRESC    4'h8
`define TWS_RST_SHIFT    8'hff
`define TWS_RST_SLAVE    8'h00
`define TWS_OP_TWO_WIRE  2'b11
`define TWS_PRESC_MIN    4'h6
`define TWS_PRESC_MAX    4'hd
`define TWS_LAST_BIT     3'h7
`define TWS_SYNC_W       3

`endif

// [rtl/tws_pkg.sv]
// Types shared by the two-wire serial channel modules.
package tws_pkg;

    typedef enum logic {
        TWS_IDLE,
        TWS_SHIFT
    } tws_state_type;

    typedef struct packed {
        tws_state_type st;
        logic [7:0]    shiftReg;
        logic [7:0]    slaveAddr;
        logic [7:0]    mode;
        logic [5:0]    busCtlHi;
        logic [7:0]    intTim;
        logic [3:0]    presc;
        logic          portLatch;
        logic          portDir;
        logic          irqFlag;
        logic          outLatch;
        logic          sckInt;
        logic          sckPrev;
        logic [2:0]    bitCnt;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
        logic          sckOe;
        logic          dataAOe;
        logic          dataBOe;
    } tws_regs_type;

    typedef struct packed {
        logic [6:0] cnt;
        logic       timPrev;
        logic       tick;
    } tws_clk_type;

    typedef struct packed {
        logic [2:0] stage1;
        logic [2:0] stage2;
    } tws_sync_type;

endpackage

// [rtl/tws_sync.sv]
// Two-flop synchroniser for the pins that the channel reads.
`timescale 1ns/100ps
`include "tws_consts.svh"

module tws_sync (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [`TWS_SYNC_W-1:0] pinIn,
    output logic      [`TWS_SYNC_W-1:0] pinSync
);
    import tws_pkg::*;

    tws_sync_type s_r;
    tws_sync_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.stage1 = pinIn;
        s_nxt.stage2 = s_r.stage1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '{stage1: '1, stage2: '1};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pinSync = s_r.stage2;
endmodule

// [rtl/tws_clkgen.sv]
// Internal serial clock source: timer output edges or a prescaler divider.
`timescale 1ns/100ps
`include "tws_consts.svh"

module tws_clkgen (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic       useTimer,
    input  wire logic [3:0] prescSel,
    input  wire logic       timerTwoOut,
    output logic            halfTick
);
    import tws_pkg::*;

    tws_clk_type c_r;
    tws_clk_type c_nxt;
    logic [7:0]  limit;
    logic        prescOk;

    // ----------------------------------------------------------------------
    // Half-period length: code n divides the system clock by 2^(n-6).
    // ----------------------------------------------------------------------
    always_comb begin
        prescOk = (prescSel >= `TWS_PRESC_MIN) && (prescSel <= `TWS_PRESC_MAX);
        limit   = (8'h01 << (prescSel - `TWS_PRESC_MIN)) - 8'h01;
    end

    always_comb begin
        c_nxt = c_r;
        c_nxt.timPrev = timerTwoOut;
        c_nxt.tick = 1'b0;
        if (!run) begin
            c_nxt.cnt = 7'h00;
        end else if (useTimer) begin
            c_nxt.tick = timerTwoOut & ~c_r.timPrev;
        end else if (prescOk) begin
            if ({1'b0, c_r.cnt} == limit) begin
                c_nxt.tick = 1'b1;
                c_nxt.cnt = 7'h00;
            end else begin
                c_nxt.cnt = c_r.cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            c_r <= '{cnt: 7'h00, timPrev: 1'b0, tick: 1'b0};
        end else begin
            c_r <= c_nxt;
        end
    end

    assign halfTick = c_r.tick;
endmodule

// [sim/tws_top_chk.sv]
// Port-level assertions for the two-wire serial channel.
`timescale 1ns/100ps

module tws_top_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serialClockLineIn,
    input wire logic serialClockLineOut,
    input wire logic serialClockLineOe,
    input wire logic dataLineAOut,
    input wire logic dataLineAOe,
    input wire logic dataLineBOut,
    input wire logic dataLineBOe,
    input wire logic channelIrq
);
    // --------
    // Checks
    // --------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_ready_once: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_wait: assert property (psel && !penable |-> ##2 pready)
        else $error("pready not in second access cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_open_drain: assert property (
        !serialClockLineOut && !dataLineAOut && !dataLineBOut)
        else $error("pin driven high");
    a_one_line: assert property (!(dataLineAOe && dataLineBOe))
        else $error("both data lines pulled");
    // A register write may move the latch; otherwise it only moves while the clock is low.
    a_data_on_fall: assert property (
        $changed({dataLineAOe, dataLineBOe})
            |-> !serialClockLineIn || $past(pready) || $past(pready, 2))
        else $error("data changed while clock high");
    a_irq_quiet: assert property (
        $rose(channelIrq) |-> (!serialClockLineOe) [*4])
        else $error("clock runs after byte end");
    a_irq_clear: assert property (
        $fell(channelIrq) |-> $past(pready) || $past(pready, 2))
        else $error("irq dropped without a write");
endmodule

bind tws_top tws_top_chk u_tws_top_chk (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .serialClockLineIn(serialClockLineIn),
    .serialClockLineOut(serialClockLineOut), .serialClockLineOe(serialClockLineOe),
    .dataLineAOut(dataLineAOut), .dataLineAOe(dataLineAOe),
    .dataLineBOut(dataLineBOut), .dataLineBOe(dataLineBOe), .channelIrq(channelIrq)
);

// [sim/tws_far_dev.sv]
// Behavioural far-side serial device on the shared clock and data lines.
`timescale 1ns/100ps

module tws_far_dev (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       sclk,
    input  wire logic       sdata,
    input  wire logic       load,
    input  wire logic [7:0] sendByte,
    output logic            dataOe,
    output logic [7:0]      rxByte
);
    logic [7:0] txBits;
    logic [3:0] bitCnt;
    logic       active;
    logic       sclkPrev;

    always_ff @(posedge clk_sys) begin
        sclkPrev <= sclk;
        if (rst) begin
            dataOe <= 1'b0;
            active <= 1'b0;
        end else if (load) begin
            txBits <= sendByte;
            bitCnt <= 4'h0;
            active <= 1'b1;
        end else if (active && sclkPrev && !sclk) begin
            // Only ever pulls low; a one is left to the pull-up.
            dataOe <= !txBits[7];
            txBits <= {txBits[6:0], 1'b1};
        end else if (active && !sclkPrev && sclk) begin
            rxByte <= {rxByte[6:0], sdata};
            bitCnt <= bitCnt + 4'h1;
            if (bitCnt == 4'h7) begin
                active <= 1'b0;
                dataOe <= 1'b0;
            end
        end
    end
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the two-wire serial channel.
`timescale 1ns/100ps
`include "tws_consts.svh"

module tb_top;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        timerTwoOut, channelIrq, partLoad, partOe, busy, extLow;
    logic        serialClockLineOut, serialClockLineOe, sclkLine, lineA, lineB;
    logic        dataLineAOut, dataLineAOe, dataLineBOut, dataLineBOe;
    logic [7:0]  partByte, partRx, exp;
    logic [1:0]  tmrCnt;
    int          fail_count, compares;
    logic [17:0] rstIdx [8] = '{`TWS_IDX_MODE, `TWS_IDX_BUSCTL, `TWS_IDX_INTTIM,
        `TWS_IDX_PRESC, `TWS_IDX_SHIFT, `TWS_IDX_SLAVE, `TWS_IDX_PORT, `TWS_IDX_STATUS};
    logic [7:0]  rstVal [8] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'hff, 8'h00, 8'h02, 8'h00};
    logic [7:0]  modeTab [6] = '{8'h9b, 8'h9b, 8'h9b, 8'h9a, 8'h9f, 8'h98};
    logic [7:0]  partTab [6] = '{8'hff, 8'h3c, 8'h0f, 8'hff, 8'hff, 8'h7e};
    logic [7:0]  txTab [6] = '{8'hc3, 8'hff, 8'hf0, 8'h5a, 8'h96, 8'he7};

    // The bench pulls the clock line low itself to act as an external clock master.
    assign sclkLine = !(serialClockLineOe || extLow);
    assign lineA    = !dataLineAOe;
    assign lineB    = !(dataLineBOe || partOe);

    tws_top u_tws_top (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timerTwoOut(timerTwoOut), .serialClockLineIn(sclkLine),
        .serialClockLineOut(serialClockLineOut), .serialClockLineOe(serialClockLineOe),
        .dataLineAIn(lineA), .dataLineAOut(dataLineAOut), .dataLineAOe(dataLineAOe),
        .dataLineBIn(lineB), .dataLineBOut(dataLineBOut), .dataLineBOe(dataLineBOe),
        .channelIrq(channelIrq)
    );
    tws_far_dev u_tws_far_dev (
        .clk_sys(clk_sys), .rst(rst), .sclk(sclkLine), .sdata(lineB), .load(partLoad),
        .sendByte(partByte), .dataOe(partOe), .rxByte(partRx)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = !clk_sys;
    end
    always @(posedge clk_sys) begin
        tmrCnt      <= tmrCnt + 2'd1;
        timerTwoOut <= tmrCnt[1];
    end

    // --------
    // Tasks
    // --------
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask
    // Pins are sampled at the falling edge; pready and read data at the rising edge.
    task automatic apb(input logic wr, input logic [17:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the watchdog bounds this wait.
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [17:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, d, rd, err);
    endtask
    task automatic rdChk(input logic [17:0] idx, input logic [7:0] want, input logic wErr);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 8'h00, rd, err);
        check(rd, {24'h0, want});
        check({31'h0, err}, {31'h0, wErr});
    endtask
    task automatic test_done();
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // --------
    // Tests
    // --------
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, partLoad, timerTwoOut, extLow} = 6'h00;
        paddr = 20'h0;
        pwdata = 32'h0;
        tmrCnt = 2'd0;
        partByte = 8'hff;
        fail_count = 0;
        compares = 0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rdChk(rstIdx[i], rstVal[i], 1'b0);
        end
        rdChk(18'h00010, 8'h00, 1'b1);
        wr(`TWS_IDX_PORT, 8'h01);
        wr(`TWS_IDX_PRESC, 8'h08);
        wr(`TWS_IDX_MODE, 8'h9b);
        wr(`TWS_IDX_INTTIM, 8'h80);
        rdChk(`TWS_IDX_INTTIM, 8'hc0, 1'b0);
        wr(`TWS_IDX_BUSCTL, 8'h02);
        @(negedge clk_sys);
        check({31'h0, dataLineBOe}, 32'h1);
        rdChk(`TWS_IDX_BUSCTL, 8'h00, 1'b0);
        wr(`TWS_IDX_BUSCTL, 8'h01);
        @(negedge clk_sys);
        check({31'h0, dataLineBOe}, 32'h0);
        wr(`TWS_IDX_PORT, 8'h00);
        @(negedge clk_sys);
        check({31'h0, serialClockLineOe}, 32'h1);
        wr(`TWS_IDX_PORT, 8'h01);
        @(negedge clk_sys);
        check({31'h0, serialClockLineOe}, 32'h0);
        wr(`TWS_IDX_MODE, 8'h1b);
        wr(`TWS_IDX_SHIFT, 8'ha5);
        wr(`TWS_IDX_SLAVE, 8'ha5);
        rdChk(`TWS_IDX_MODE, 8'h1b, 1'b0);
        rdChk(`TWS_IDX_INTTIM, 8'h80, 1'b0);
        wr(`TWS_IDX_MODE, 8'h9b);
        busy = 1'b0;
        repeat (80) begin
            @(negedge clk_sys);
            busy = busy | serialClockLineOe;
        end
        check({31'h0, busy}, 32'h0);
        rdChk(`TWS_IDX_MODE, 8'hdb, 1'b0);
        for (int i = 0; i < 6; i++) begin
            exp = modeTab[i][2] ? txTab[i] : (txTab[i] & partTab[i]);
            wr(`TWS_IDX_MODE, modeTab[i]);
            partByte <= partTab[i];
            partLoad <= 1'b1;
            @(posedge clk_sys);
            partLoad <= 1'b0;
            wr(`TWS_IDX_SLAVE, txTab[i]);
            wr(`TWS_IDX_SHIFT, txTab[i]);
            if (!modeTab[i][1]) begin
                repeat (8) begin
                    extLow <= 1'b1;
                    repeat (4) @(posedge clk_sys);
                    extLow <= 1'b0;
                    repeat (4) @(posedge clk_sys);
                end
            end
            for (int n = 0; n < 500 && channelIrq !== 1'b1; n++) begin
                @(negedge clk_sys);
            end
            check({31'h0, channelIrq}, 32'h1);
            rdChk(`TWS_IDX_SHIFT, exp, 1'b0);
            rdChk(`TWS_IDX_MODE, modeTab[i] | (exp == txTab[i] ? 8'h40 : 8'h00), 1'b0);
            if (!modeTab[i][2]) begin
                check({24'h0, partRx}, {24'h0, exp});
            end
            wr(`TWS_IDX_STATUS, 8'h01);
            rdChk(`TWS_IDX_STATUS, 8'h00, 1'b0);
        end
        test_done();
    end

    initial begin
        #100000;
        fail_count++;
        test_done();
    end
endmodule
